/* src/bcc_map.svh */
// register offsets, field positions and reset values of the branch cache
`ifndef BCC_MAP_SVH
`define BCC_MAP_SVH
`define BCC_CTRL_ADDR 8'h84
`define BCC_FSTAT_ADDR 8'hac
`define BCC_TUNE_ADDR 8'hc9
`define BCC_LOCK_ADDR 8'hd2
`define BCC_ACC_ADDR 8'hd3
`define BCC_CTRL_RST 8'he6
`define BCC_FSTAT_RST 8'h00
`define BCC_TUNE_RST 8'h04
`define BCC_LOCK_RST 8'h1f
`define BCC_ACC_RST 8'h00
`define BCC_CWE_BIT 7
`define BCC_CRE_BIT 6
`define BCC_PFE_BIT 5
`define BCC_FLUSH_BIT 4
`define BCC_RETI_BIT 3
`define BCC_ISR_BIT 2
`define BCC_MOVC_BIT 1
`define BCC_BLKW_BIT 0
`define BCC_ALG_BIT 3
`define BCC_FIX_BIT 2
`define BCC_PUSH_BIT 7
`define BCC_POP_BIT 6
`define BCC_OVF_BIT 7
`define BCC_BUSY_BIT 0
`define BCC_ACC_W 12
`define BCC_ACC_MAX 12'hfff
`define BCC_ACC_ONE 12'h001
`define BCC_PTR_W 5
`define BCC_LAST_SLOT 5'h1f
`define BCC_STALL_SAT 3'h4
`define BCC_LFSR_SEED 5'h01
`define BCC_TAG_W 13
`endif

/* src/bcc_pkg.sv */
// state types of the branch cache control logic
package bcc_pkg;
  `include "bcc_map.svh"

  typedef struct packed {
    logic cwe;
    logic cre;
    logic pfe;
    logic reti;
    logic isr;
    logic movc;
    logic blkw;
    logic alg;
    logic fix;
    logic [1:0] thr;
    logic push_en;
    logic [`BCC_PTR_W-1:0] ptr;
    logic [2:0] stall;
    logic [7:0] rdata;
    logic flush;
    logic wr;
    logic [`BCC_PTR_W-1:0] wr_slot;
    logic wr_lock;
    logic [`BCC_TAG_W-1:0] wr_tag;
    logic unlock;
    logic [`BCC_PTR_W-1:0] unlock_slot;
    logic inval;
    logic [15:0] inval_addr;
  } bcc_state_t;

  typedef struct packed {
    logic [`BCC_ACC_W-1:0] acc;
    logic ovf;
    logic [3:0] snap;
  } bcc_acc_t;

  typedef struct packed {
    logic [`BCC_PTR_W-1:0] pos;
    logic down;
    logic [`BCC_PTR_W-1:0] lfsr;
  } bcc_repl_t;
endpackage

/* src/bcc_penalty_acc.sv */
// miss penalty accumulator with overflow flag and low-field snapshot
`timescale 1ns/10ps
`default_nettype none
`include "bcc_map.svh"
module bcc_penalty_acc (
  input wire logic clk,
  input wire logic rstn,
  input wire logic stall_tick,
  input wire logic high_wr,
  input wire logic [6:0] high_wdata,
  input wire logic high_rd,
  output logic [6:0] acc_high,
  output logic acc_overflow,
  output logic [3:0] low_snap
);
  bcc_pkg::bcc_acc_t s_reg;
  bcc_pkg::bcc_acc_t s_next;

  always_comb
  begin
    s_next = s_reg;
    if (high_wr)
    begin
      // load high field, clear low five bits and the flag
      s_next.acc = {high_wdata, 5'h00};
      s_next.ovf = 1'b0;
    end
    else if (stall_tick)
    begin
      s_next.acc = s_reg.acc + `BCC_ACC_ONE;
      if (s_reg.acc == `BCC_ACC_MAX)
      begin
        s_next.ovf = 1'b1;
      end
    end
    if (high_rd)
    begin
      s_next.snap = s_reg.acc[4:1];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign acc_high = s_reg.acc[11:5];
  assign acc_overflow = s_reg.ovf;
  assign low_snap = s_reg.snap;

  acc_count_a:
  assert property (@(posedge clk) disable iff (!rstn)
    stall_tick && !high_wr |=> s_reg.acc == $past(s_reg.acc) + 12'h001)
  else $error("accumulator did not count a stall cycle");

  acc_wrap_a:
  assert property (@(posedge clk) disable iff (!rstn)
    stall_tick && !high_wr && s_reg.acc == 12'hfff
    |=> s_reg.ovf && s_reg.acc == 12'h000 ##1 s_reg.ovf || $past(high_wr))
  else $error("overflow flag not set and held on wrap");

  snap_hold_a:
  assert property (@(posedge clk) disable iff (!rstn)
    !high_rd |=> $stable(s_reg.snap))
  else $error("low snapshot changed without a high field read");
endmodule
`default_nettype wire

/* src/bcc_replace.sv */
// slot chooser: rebound walk or pseudo-random pick below the lock stack
`timescale 1ns/10ps
`default_nettype none
`include "bcc_map.svh"
module bcc_replace (
  input wire logic clk,
  input wire logic rstn,
  input wire logic advance,
  input wire logic random_sel,
  input wire logic [4:0] limit,
  output logic [4:0] slot
);
  bcc_pkg::bcc_repl_t s_reg;
  bcc_pkg::bcc_repl_t s_next;

  always_comb
  begin
    s_next = s_reg;
    s_next.lfsr = {s_reg.lfsr[3:0], s_reg.lfsr[4] ^ s_reg.lfsr[2]};
    if (advance && !random_sel)
    begin
      if (s_reg.pos > limit)
      begin
        s_next.pos = limit;
        s_next.down = 1'b1;
      end
      else if (s_reg.down)
      begin
        if (s_reg.pos == 5'h00)
        begin
          s_next.pos = (limit == 5'h00) ? 5'h00 : 5'h01;
          s_next.down = 1'b0;
        end
        else
        begin
          s_next.pos = s_reg.pos - 5'h01;
        end
      end
      else if (s_reg.pos >= limit)
      begin
        s_next.pos = (limit == 5'h00) ? 5'h00 : limit - 5'h01;
        s_next.down = 1'b1;
      end
      else
      begin
        s_next.pos = s_reg.pos + 5'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_reg <= '0;
      s_reg.lfsr <= `BCC_LFSR_SEED;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // masking with the limit never yields a slot above it
  assign slot = random_sel ? (s_reg.lfsr & limit) :
    ((s_reg.pos > limit) ? limit : s_reg.pos);

  slot_in_range_a:
  assert property (@(posedge clk) disable iff (!rstn)
    slot <= limit)
  else $error("replacement slot above the unlocked range");
endmodule
`default_nettype wire

/* src/bcc_ctrl.sv */
// branch target cache control, tuning, lock stack and diagnostics
// What this block does
// - cache write enable clear blocks normal writes
// - cache read enable gates use of hits
// - prefetch runs only with prefetch enable
// - flush bit invalidates cache, reads zero
// - return targets cached only when enabled
// - interrupt routine code cached only when enabled
// - code reads cached only when enabled, or locked by push regardless
// - block write selects four byte flash writes
// - algorithm bit picks rebound or random
// - fixed bit forces code read data slot 0
// - cache a miss only above threshold
// - tuning upper bits show latched low accumulator
// - push locks code read segment, decrements pointer
// - pop increments pointer, unlocks, reads zero
// - slots above pointer locked unless zero
// - accumulator counts every miss stall cycle
// - overflow flag sticks until register written
// - high write loads, read latches low bits
// - flash status shows write or erase busy
// - rebound walks up then down
// - flash modify invalidates affected bytes always
`timescale 1ns/10ps
`default_nettype none
`include "bcc_map.svh"
module bcc_ctrl (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic core_stall,
  input wire logic fill_valid,
  input wire logic [12:0] fill_tag,
  input wire logic fill_is_reti,
  input wire logic fill_in_isr,
  input wire logic fill_is_movc,
  input wire logic flash_busy,
  input wire logic flash_modify,
  input wire logic [15:0] flash_addr,
  output logic cache_read_allow,
  output logic prefetch_allow,
  output logic flash_block_write,
  output logic cache_flush,
  output logic cache_wr,
  output logic [4:0] cache_wr_slot,
  output logic [12:0] cache_wr_tag,
  output logic cache_wr_lock,
  output logic cache_unlock,
  output logic [4:0] cache_unlock_slot,
  output logic cache_inval,
  output logic [15:0] cache_inval_addr
);
  localparam logic [7:0] CTRL_RST = `BCC_CTRL_RST;
  localparam logic [7:0] TUNE_RST = `BCC_TUNE_RST;
  localparam logic [7:0] LOCK_RST = `BCC_LOCK_RST;

  bcc_pkg::bcc_state_t s_reg;
  bcc_pkg::bcc_state_t s_next;

  logic ctrl_wr;
  logic tune_wr;
  logic lock_wr;
  logic acc_wr;
  logic acc_rd;
  logic pop_ev;
  logic push_ev;
  logic fill_ok;
  logic keep_fill;
  logic fixed_slot;
  logic [4:0] limit;
  logic [4:0] repl_slot;
  logic [6:0] acc_high;
  logic acc_overflow;
  logic [3:0] low_snap;
  logic [7:0] read_val;

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
    reg_hit = (a == off);
  endfunction

  assign ctrl_wr = sfr_wr && reg_hit(sfr_addr, `BCC_CTRL_ADDR);
  assign tune_wr = sfr_wr && reg_hit(sfr_addr, `BCC_TUNE_ADDR);
  assign lock_wr = sfr_wr && reg_hit(sfr_addr, `BCC_LOCK_ADDR);
  assign acc_wr = sfr_wr && reg_hit(sfr_addr, `BCC_ACC_ADDR);
  assign acc_rd = sfr_rd && reg_hit(sfr_addr, `BCC_ACC_ADDR);
  assign pop_ev = lock_wr && sfr_wdata[`BCC_POP_BIT];

  // each code read while push is on locks its segment
  assign push_ev = fill_valid && fill_is_movc && s_reg.push_en;

  // per-type exclusions
  assign fill_ok = (!fill_is_reti || s_reg.reti) &&
    (!fill_in_isr || s_reg.isr) &&
    (!fill_is_movc || s_reg.movc);

  // instruction misses need a long enough stall, code reads do not
  assign keep_fill = fill_valid && !push_ev && s_reg.cwe && fill_ok &&
    (fill_is_movc || s_reg.stall > {1'b0, s_reg.thr});

  assign fixed_slot = fill_is_movc && s_reg.fix;

  // slots above the pointer are out of reach, all free at zero
  assign limit = (s_reg.ptr == 5'h00) ? `BCC_LAST_SLOT : s_reg.ptr;

  bcc_replace u_replace (
    .clk(clk),
    .rstn(rstn),
    .advance(keep_fill && !fixed_slot),
    .random_sel(s_reg.alg),
    .limit(limit),
    .slot(repl_slot)
  );

  bcc_penalty_acc u_acc (
    .clk(clk),
    .rstn(rstn),
    .stall_tick(core_stall),
    .high_wr(acc_wr),
    .high_wdata(sfr_wdata[6:0]),
    .high_rd(acc_rd),
    .acc_high(acc_high),
    .acc_overflow(acc_overflow),
    .low_snap(low_snap)
  );

  always_comb
  begin
    read_val = 8'h00;
    case (sfr_addr)
      `BCC_CTRL_ADDR:
        read_val = {s_reg.cwe, s_reg.cre, s_reg.pfe, 1'b0,
          s_reg.reti, s_reg.isr, s_reg.movc, s_reg.blkw};
      `BCC_TUNE_ADDR:
        read_val = {low_snap, s_reg.alg, s_reg.fix, s_reg.thr};
      `BCC_LOCK_ADDR:
        read_val = {s_reg.push_en, 2'b00, s_reg.ptr};
      `BCC_ACC_ADDR:
        read_val = {acc_overflow, acc_high};
      `BCC_FSTAT_ADDR:
        read_val = {7'h00, flash_busy};
      default:
        read_val = 8'h00;
    endcase
  end

  always_comb
  begin
    s_next = s_reg;
    s_next.flush = 1'b0;
    s_next.wr = 1'b0;
    s_next.wr_lock = 1'b0;
    s_next.unlock = 1'b0;
    s_next.inval = 1'b0;
    if (sfr_rd)
    begin
      s_next.rdata = read_val;
    end
    if (ctrl_wr)
    begin
      s_next.cwe = sfr_wdata[`BCC_CWE_BIT];
      s_next.cre = sfr_wdata[`BCC_CRE_BIT];
      s_next.pfe = sfr_wdata[`BCC_PFE_BIT];
      s_next.flush = sfr_wdata[`BCC_FLUSH_BIT];
      s_next.reti = sfr_wdata[`BCC_RETI_BIT];
      s_next.isr = sfr_wdata[`BCC_ISR_BIT];
      s_next.movc = sfr_wdata[`BCC_MOVC_BIT];
      s_next.blkw = sfr_wdata[`BCC_BLKW_BIT];
    end
    if (tune_wr)
    begin
      s_next.alg = sfr_wdata[`BCC_ALG_BIT];
      s_next.fix = sfr_wdata[`BCC_FIX_BIT];
      s_next.thr = sfr_wdata[1:0];
    end
    if (lock_wr)
    begin
      s_next.push_en = sfr_wdata[`BCC_PUSH_BIT];
    end
    // stall length of the miss now being filled
    if (fill_valid)
    begin
      s_next.stall = 3'h0;
    end
    else if (core_stall && s_reg.stall != `BCC_STALL_SAT)
    begin
      s_next.stall = s_reg.stall + 3'h1;
    end
    if (push_ev)
    begin
      s_next.wr = 1'b1;
      s_next.wr_lock = 1'b1;
      s_next.wr_slot = s_reg.ptr;
      s_next.wr_tag = fill_tag;
    end
    else if (keep_fill)
    begin
      s_next.wr = 1'b1;
      s_next.wr_slot = fixed_slot ? 5'h00 : repl_slot;
      s_next.wr_tag = fill_tag;
    end
    case ({pop_ev, push_ev})
      2'b10:
      begin
        s_next.ptr = s_reg.ptr + 5'h01;
        s_next.unlock = 1'b1;
        s_next.unlock_slot = s_reg.ptr + 5'h01;
      end
      2'b01:
        s_next.ptr = s_reg.ptr - 5'h01;
      2'b11:
      begin
        s_next.unlock = 1'b1;
        s_next.unlock_slot = s_reg.ptr;
      end
      default:
        s_next.ptr = s_reg.ptr;
    endcase
    // flash program and erase evict regardless of write enable
    if (flash_modify)
    begin
      s_next.inval = 1'b1;
      s_next.inval_addr = flash_addr;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_reg <= '0;
      s_reg.cwe <= CTRL_RST[`BCC_CWE_BIT];
      s_reg.cre <= CTRL_RST[`BCC_CRE_BIT];
      s_reg.pfe <= CTRL_RST[`BCC_PFE_BIT];
      s_reg.reti <= CTRL_RST[`BCC_RETI_BIT];
      s_reg.isr <= CTRL_RST[`BCC_ISR_BIT];
      s_reg.movc <= CTRL_RST[`BCC_MOVC_BIT];
      s_reg.blkw <= CTRL_RST[`BCC_BLKW_BIT];
      s_reg.alg <= TUNE_RST[`BCC_ALG_BIT];
      s_reg.fix <= TUNE_RST[`BCC_FIX_BIT];
      s_reg.thr <= TUNE_RST[1:0];
      s_reg.push_en <= LOCK_RST[`BCC_PUSH_BIT];
      s_reg.ptr <= LOCK_RST[4:0];
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign sfr_rdata = s_reg.rdata;
  assign cache_read_allow = s_reg.cre;
  assign prefetch_allow = s_reg.pfe;
  assign flash_block_write = s_reg.blkw;
  assign cache_flush = s_reg.flush;
  assign cache_wr = s_reg.wr;
  assign cache_wr_slot = s_reg.wr_slot;
  assign cache_wr_tag = s_reg.wr_tag;
  assign cache_wr_lock = s_reg.wr_lock;
  assign cache_unlock = s_reg.unlock;
  assign cache_unlock_slot = s_reg.unlock_slot;
  assign cache_inval = s_reg.inval;
  assign cache_inval_addr = s_reg.inval_addr;

  flush_pulse_a:
  assert property (@(posedge clk) disable iff (!rstn)
    ctrl_wr && sfr_wdata[4] |=> cache_flush ##1 !cache_flush)
  else $error("flush write did not give a one cycle flush");

  flush_reads_zero_a:
  assert property (@(posedge clk) disable iff (!rstn)
    sfr_rd && sfr_addr == 8'h84 |=> !sfr_rdata[4])
  else $error("flush bit read back as one");

  write_gate_a:
  assert property (@(posedge clk) disable iff (!rstn)
    cache_wr && !cache_wr_lock |-> $past(s_reg.cwe))
  else $error("normal cache write with write enable clear");

  miss_threshold_a:
  assert property (@(posedge clk) disable iff (!rstn)
    cache_wr && !cache_wr_lock && !$past(fill_is_movc)
    |-> $past(s_reg.stall) > {1'b0, $past(s_reg.thr)})
  else $error("miss cached at or below threshold");

  push_lock_a:
  assert property (@(posedge clk) disable iff (!rstn)
    push_ev && !pop_ev |=> cache_wr && cache_wr_lock &&
    cache_wr_slot == $past(s_reg.ptr) && s_reg.ptr == $past(s_reg.ptr) - 5'h01)
  else $error("push did not lock slot and decrement pointer");

  pop_unlock_a:
  assert property (@(posedge clk) disable iff (!rstn)
    pop_ev && !push_ev |=> cache_unlock && s_reg.ptr == $past(s_reg.ptr) + 5'h01
    && cache_unlock_slot == s_reg.ptr ##1 !cache_unlock)
  else $error("pop did not raise pointer and unlock that slot");

  lock_protect_a:
  assert property (@(posedge clk) disable iff (!rstn)
    cache_wr && !cache_wr_lock && $past(s_reg.ptr) != 5'h00
    |-> cache_wr_slot <= $past(s_reg.ptr))
  else $error("normal write landed in a locked slot");

  flash_inval_a:
  assert property (@(posedge clk) disable iff (!rstn)
    flash_modify |=> cache_inval && cache_inval_addr == $past(flash_addr))
  else $error("flash modify did not invalidate");
endmodule
`default_nettype wire

/* bench/bcc_core_model.sv */
// core fetch and flash partner model for the branch cache control
`timescale 1ns/10ps
`default_nettype none
module bcc_core_model (
  input wire logic clk,
  output logic core_stall,
  output logic fill_valid,
  output logic [12:0] fill_tag,
  output logic fill_is_reti,
  output logic fill_in_isr,
  output logic fill_is_movc,
  output logic flash_busy,
  output logic flash_modify,
  output logic [15:0] flash_addr
);
  initial
  begin
    core_stall = 1'b0;
    fill_valid = 1'b0;
    fill_tag = 13'h0aaa;
    fill_is_reti = 1'b1;
    fill_in_isr = 1'b1;
    fill_is_movc = 1'b1;
    flash_busy = 1'b0;
    flash_modify = 1'b0;
    flash_addr = 16'h5555;
  end
  // core held by a miss for n cycles
  task automatic stall(input int n);
    repeat (n)
    begin
      @(negedge clk);
      core_stall = 1'b1;
    end
    @(negedge clk);
    core_stall = 1'b0;
  endtask
  // one segment delivered, qualifiers scrambled afterwards
  task automatic fill(input logic [12:0] t, input logic r, input logic i,
                      input logic m);
    @(negedge clk);
    fill_valid = 1'b1;
    fill_tag = t;
    {fill_is_reti, fill_in_isr, fill_is_movc} = {r, i, m};
    @(negedge clk);
    fill_valid = 1'b0;
    fill_tag = ~t;
    {fill_is_reti, fill_in_isr, fill_is_movc} = ~{r, i, m};
  endtask
  // one flash byte written or erased
  task automatic modify(input logic [15:0] a);
    @(negedge clk);
    flash_modify = 1'b1;
    flash_addr = a;
    @(negedge clk);
    flash_modify = 1'b0;
    flash_addr = ~a;
  endtask
endmodule
`default_nettype wire

/* bench/branch_cache_control_test.sv */
// self-checking bench for the branch cache control
`timescale 1ns/10ps
`default_nettype none
`include "bcc_map.svh"
module branch_cache_control_test;
  logic clk, rstn, sfr_wr, sfr_rd, core_stall, fill_valid, fill_is_reti;
  logic fill_in_isr, fill_is_movc, flash_busy, flash_modify;
  logic cache_read_allow, prefetch_allow, flash_block_write, cache_flush;
  logic cache_wr, cache_wr_lock, cache_unlock, cache_inval;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [12:0] fill_tag, cache_wr_tag;
  logic [4:0] cache_wr_slot, cache_unlock_slot;
  logic [15:0] flash_addr, cache_inval_addr;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;

  bcc_ctrl uut (.clk(clk), .rstn(rstn), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .core_stall(core_stall), .fill_valid(fill_valid),
    .fill_tag(fill_tag), .fill_is_reti(fill_is_reti),
    .fill_in_isr(fill_in_isr), .fill_is_movc(fill_is_movc),
    .flash_busy(flash_busy), .flash_modify(flash_modify),
    .flash_addr(flash_addr), .cache_read_allow(cache_read_allow),
    .prefetch_allow(prefetch_allow), .flash_block_write(flash_block_write),
    .cache_flush(cache_flush), .cache_wr(cache_wr),
    .cache_wr_slot(cache_wr_slot), .cache_wr_tag(cache_wr_tag),
    .cache_wr_lock(cache_wr_lock), .cache_unlock(cache_unlock),
    .cache_unlock_slot(cache_unlock_slot), .cache_inval(cache_inval),
    .cache_inval_addr(cache_inval_addr));

  bcc_core_model cm (.clk(clk), .core_stall(core_stall),
    .fill_valid(fill_valid), .fill_tag(fill_tag),
    .fill_is_reti(fill_is_reti), .fill_in_isr(fill_in_isr),
    .fill_is_movc(fill_is_movc), .flash_busy(flash_busy),
    .flash_modify(flash_modify), .flash_addr(flash_addr));

  initial clk = 1'b0;
  always #2 clk = ~clk;

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic do_reset();
    @(negedge clk);
    rstn = 1'b0;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    sfr_wdata = ~d;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    chk(16'(sfr_rdata), 16'(e));
  endtask

  // fill accepted: write enable, type exclusions, threshold on instructions
  function automatic logic exp_wr(input logic [7:0] c, input logic [1:0] th,
                                  input int n, input logic [2:0] f);
    int s;
    s = (n > 4) ? 4 : n;
    return c[7] & ~(f[2] & ~c[3]) & ~(f[1] & ~c[2]) & ~(f[0] & ~c[1])
           & (f[0] | (s > th));
  endfunction

  task automatic fchk(input logic [7:0] c, input logic [7:0] t, input int n,
                      input logic [2:0] f);
    logic [12:0] g;
    logic e;
    g = 13'($urandom);
    e = exp_wr(c, t[1:0], n, f);
    wr(`BCC_CTRL_ADDR, c);
    wr(`BCC_TUNE_ADDR, t);
    cm.stall(n);
    cm.fill(g, f[2], f[1], f[0]);
    chk(16'(cache_wr), 16'(e));
    if (e)
      chk(16'(cache_wr_tag), 16'(g));
    if (e & f[0] & t[2])
      chk(16'(cache_wr_slot), 16'h0000);
  endtask

  initial
  begin
    logic [7:0] d;
    logic [4:0] s;
    logic [15:0] a;
    rstn = 1'b1;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    void'($urandom(32'h267c));
    #1 rstn = 1'b0;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    // reset values, unmapped address reads zero
    rdchk(`BCC_CTRL_ADDR, 8'he6);
    rdchk(`BCC_FSTAT_ADDR, 8'h00);
    rdchk(`BCC_TUNE_ADDR, 8'h04);
    rdchk(`BCC_LOCK_ADDR, 8'h1f);
    rdchk(`BCC_ACC_ADDR, 8'h00);
    rdchk(8'h85, 8'h00);
    chk(16'({cache_read_allow, prefetch_allow, flash_block_write}),
        16'h0006);
    // control writes: levels, flush pulse, flush reads zero
    repeat (8)
    begin
      d = 8'($urandom);
      wr(`BCC_CTRL_ADDR, d);
      chk(16'(cache_flush), 16'(d[4]));
      chk(16'({cache_read_allow, prefetch_allow, flash_block_write}),
          16'({d[6], d[5], d[0]}));
      rdchk(`BCC_CTRL_ADDR, d & 8'hef);
    end
    // flash busy and byte invalidation with writes disabled
    cm.flash_busy = 1'b1;
    rdchk(`BCC_FSTAT_ADDR, 8'h01);
    cm.flash_busy = 1'b0;
    rdchk(`BCC_FSTAT_ADDR, 8'h00);
    wr(`BCC_CTRL_ADDR, 8'h00);
    a = 16'($urandom);
    cm.modify(a);
    chk(16'(cache_inval), 16'h0001);
    chk(cache_inval_addr, a);
    // threshold corners, then random fills
    fchk(8'he6, 8'h03, 3, 3'b000);
    fchk(8'he6, 8'h03, 4, 3'b000);
    fchk(8'he6, 8'h03, 6, 3'b000);
    repeat (40)
      fchk(8'($urandom) & 8'hef, 8'($urandom) & 8'h0f, $urandom_range(0, 5),
           3'($urandom));
    // rebound walk up then back down
    do_reset();
    wr(`BCC_TUNE_ADDR, 8'h00);
    s = 5'h00;
    for (int k = 0; k < 34; k++)
    begin
      cm.stall(1);
      cm.fill(13'(k), 1'b0, 1'b0, 1'b0);
      if (k < 32)
        chk(16'(cache_wr_slot), 16'(k));
      else if (k == 33)
        chk(16'(cache_wr_slot), 16'(s - 5'h01));
      s = cache_wr_slot;
    end
    // push three code-read segments with writes disabled, then pop one
    wr(`BCC_LOCK_ADDR, 8'h80);
    wr(`BCC_CTRL_ADDR, 8'h60);
    for (int p = 0; p < 3; p++)
    begin
      cm.fill(13'($urandom), 1'b0, 1'b0, 1'b1);
      chk(16'({cache_wr, cache_wr_lock, cache_wr_slot}),
          16'({2'b11, 5'(31 - p)}));
    end
    rdchk(`BCC_LOCK_ADDR, 8'h9c);
    wr(`BCC_LOCK_ADDR, 8'hc0);
    chk(16'({cache_unlock, cache_unlock_slot}), 16'h003d);
    rdchk(`BCC_LOCK_ADDR, 8'h9d);
    // random replacement stays below the lock stack
    wr(`BCC_LOCK_ADDR, 8'h00);
    wr(`BCC_CTRL_ADDR, 8'he6);
    wr(`BCC_TUNE_ADDR, 8'h08);
    repeat (8)
    begin
      cm.stall(2);
      cm.fill(13'($urandom), 1'b0, 1'b0, 1'b0);
      chk(16'({cache_wr, cache_wr_slot <= 5'h1d}), 16'h0003);
    end
    // accumulator load, count, snapshot
    do_reset();
    wr(`BCC_ACC_ADDR, 8'h85);
    cm.stall(37);
    rdchk(`BCC_ACC_ADDR, 8'h06);
    cm.stall(6);
    rdchk(`BCC_TUNE_ADDR, 8'h24);
    // wrap with sticky overflow, cleared by a write
    wr(`BCC_ACC_ADDR, 8'h7f);
    cm.stall(40);
    rdchk(`BCC_ACC_ADDR, 8'h80);
    rdchk(`BCC_TUNE_ADDR, 8'h44);
    cm.stall(3);
    rdchk(`BCC_ACC_ADDR, 8'h80);
    wr(`BCC_ACC_ADDR, 8'h00);
    rdchk(`BCC_ACC_ADDR, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
